// ---- hdl/arp_pkg.sv ----
// Purpose: Shared constants, types and helpers for the aux result and
//          cell range select block.
// Assumes: Avalon-MM byte addresses; each register is one 32-bit word.
// Notes:   Printed offsets are word indexes; byte address = 4 * index.
package arp_pkg;

	// Register word indexes
	localparam logic [7:0] IDX_SIDE_RESULT_THREE     = 8'h5C;
	localparam logic [7:0] IDX_SIDE_RESULT_FOUR     = 8'h5D;
	localparam logic [7:0] IDX_SIDE_RESULT_FIVE     = 8'h5E;
	localparam logic [7:0] IDX_RANGE    = 8'h5F;
	localparam logic [7:0] IDX_THR_BASE = 8'h70;
	localparam logic [7:0] IDX_SIDE_CFG = 8'h75;
	localparam logic [7:0] IDX_LOWEST   = 8'h76;
	localparam logic [7:0] IDX_HIGHEST  = 8'h77;
	localparam logic [7:0] IDX_STATUS   = 8'h78;
	localparam logic [7:0] IDX_MASK     = 8'h79;

	// Threshold slots, at IDX_THR_BASE + slot
	localparam int THR_OVER     = 0;
	localparam int THR_UNDER    = 1;
	localparam int THR_BIP_OVER = 2;
	localparam int THR_BIP_UNDR = 3;
	localparam int THR_MISMATCH = 4;
	localparam int THR_NUM      = 5;

	// Field positions
	localparam int EXT_SEL_BIT  = 15;
	localparam int CELL_NUM     = 14;
	localparam int AUX_NUM      = 3;
	localparam int SIDE_EN_LSB  = 3;

	// Event and status bits
	localparam int EV_OVER      = 0;
	localparam int EV_UNDER     = 1;
	localparam int EV_COMP_OVER = 2;
	localparam int EV_COMP_UNDR = 3;
	localparam int EV_MISMATCH  = 4;
	localparam int EV_DIAG      = 5;
	localparam int EV_NUM       = 6;

	// Reset values
	localparam logic [13:0] RST_POL      = 14'h0000;
	localparam logic        RST_EXT_SEL  = 1'b0;
	localparam logic [13:0] RST_THR      = 14'h0000;
	localparam logic [5:0]  RST_SIDE_CFG = 6'h00;
	localparam logic [5:0]  RST_MASK     = 6'h00;
	localparam logic [13:0] RST_RESULT   = 14'h0000;

	// Avalon response codes
	localparam logic [1:0] RESP_OK     = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SCAN_ADC  = 2'b00,
		SCAN_COMP = 2'b01,
		SCAN_DIAG = 2'b10
	} arp_scan_e;

	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ACK  = 1'b1
	} arp_bus_e;

	// Bipolar codes are two's complement, unipolar codes are unsigned
	function automatic logic exceeds(input logic [13:0] a,
		input logic [13:0] b, input logic sgn);
		exceeds = sgn ? ($signed(a) > $signed(b)) : (a > b);
	endfunction

	function automatic logic [14:0] ext15(input logic [13:0] v,
		input logic sgn);
		ext15 = {sgn & v[13], v};
	endfunction

	// Byte-lane merge of a 14-bit field held in bits 13:0
	function automatic logic [13:0] merge14(input logic [13:0] old,
		input logic [31:0] d, input logic [3:0] be);
		merge14 = {be[1] ? d[13:8] : old[13:8],
			be[0] ? d[7:0] : old[7:0]};
	endfunction

endpackage

// ---- hdl/arp_aux_slot.sv ----
// Purpose: One auxiliary result holder with its read-back word.
// Assumes: The engine gives no load for a channel it skipped.
// Notes:   Stored value survives while the pin is not analogue.
`timescale 1ns/100ps
module arp_aux_slot (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        analog_side_input_i,
	input  wire logic        side_channel_measure_enable_i,
	input  wire logic        load_i,
	input  wire logic [13:0] value_i,
	output logic      [15:0] word_o
);

	logic [13:0] val_q;
	wire         take = load_i & analog_side_input_i
		& side_channel_measure_enable_i;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			val_q <= arp_pkg::RST_RESULT;
		end else if (take) begin
			val_q <= value_i;
		end
	end

	// Left aligned, low two bits zero; zero when not analogue
	assign word_o = analog_side_input_i ? {val_q, 2'b00}
		: 16'h0000;

endmodule

// ---- hdl/arp_cell_eval.sv ----
// Purpose: Threshold check of one cell result per cycle.
// Assumes: One result per valid cycle, polarity of that cell given.
// Notes:   Outputs are registered one-cycle event pulses.
`timescale 1ns/100ps
module arp_cell_eval (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        valid_i,
	input  wire logic [1:0]  kind_i,
	input  wire logic [13:0] value_i,
	input  wire logic        bipolar_i,
	input  wire logic [13:0] cell_over_threshold_i,
	input  wire logic [13:0] cell_under_threshold_i,
	input  wire logic [13:0] bipolar_over_threshold_i,
	input  wire logic [13:0] bipolar_under_threshold_i,
	output logic             over_o,
	output logic             under_o,
	output logic             comparator_over_alert_o,
	output logic             comparator_under_alert_o,
	output logic             diag_fault_o
);

	// Bipolar cells use their own pair of limits
	wire [13:0] thr_hi = bipolar_i ? bipolar_over_threshold_i
		: cell_over_threshold_i;
	wire [13:0] thr_lo = bipolar_i ? bipolar_under_threshold_i
		: cell_under_threshold_i;
	wire        hi = arp_pkg::exceeds(value_i, thr_hi, bipolar_i);
	wire        lo = arp_pkg::exceeds(thr_lo, value_i, bipolar_i);

	wire is_adc  = valid_i & (kind_i == arp_pkg::SCAN_ADC);
	wire is_comp = valid_i & (kind_i == arp_pkg::SCAN_COMP)
		& ~bipolar_i;
	wire is_diag = valid_i & (kind_i == arp_pkg::SCAN_DIAG)
		& ~bipolar_i;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			over_o                   <= 1'b0;
			under_o                  <= 1'b0;
			comparator_over_alert_o  <= 1'b0;
			comparator_under_alert_o <= 1'b0;
			diag_fault_o             <= 1'b0;
		end else begin
			over_o                   <= is_adc & hi;
			under_o                  <= is_adc & lo;
			comparator_over_alert_o  <= is_comp & hi;
			comparator_under_alert_o <= is_comp & lo;
			diag_fault_o             <= is_diag & (hi | lo);
		end
	end

endmodule

// ---- hdl/arp_top.sv ----
// Purpose: Aux channel 3..5 results and per-cell range select, with
//          threshold events, extremes tracking and an interrupt.
// Assumes: Avalon-MM slave with waitrequest; results arrive from the
//          acquisition engine synchronous to ref_clk_i.
// Notes:   Every access is answered in the cycle after it is seen.
//
// How it works
// - Aux result word holds the 14-bit value in bits 15 to 2.
// - Aux results are read-only, latest value; writes leave them alone.
// - A pin not set as analogue input reads back zero.
// - Enable clear and channel skipped keeps the stored result.
// - Extremes select clear: only unipolar cells feed min, max, mismatch.
// - Extremes select set: only bipolar cells feed min, max, mismatch.
// - Range bit zero means unipolar 0 to 5 V; reset default.
// - Range bit one means bipolar -2.5 V to 2.5 V.
// - Bipolar cells raise no faults in balance-switch diagnostic scans.
// - Bipolar cells use the bipolar over and under limits.
// - Bipolar cells are left out of comparator scans and alerts.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/100ps
module arp_top (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic [9:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	output logic      [1:0]  avs_response_o,
	input  wire logic        cell_valid_i,
	input  wire logic [3:0]  cell_index_i,
	input  wire logic [13:0] cell_value_i,
	input  wire logic [1:0]  scan_kind_i,
	input  wire logic        scan_end_i,
	input  wire logic        aux_valid_i,
	input  wire logic [1:0]  aux_index_i,
	input  wire logic [13:0] aux_value_i,
	output logic      [13:0] cell_bipolar_o,
	output logic             cell_mismatch_alert_o,
	output logic             irq_o
);


	// Bus side decode
	wire        [7:0]  idx = avs_address_i[9:2];
	wire               rq  = avs_read_i | avs_write_i;
	wire        [3:0]  be  = avs_byteenable_i;
	wire        [31:0] wd  = avs_writedata_i;

	arp_pkg::arp_bus_e bus_q;
	arp_pkg::arp_bus_e bus_d;
	logic              wait_q;
	logic       [31:0] rdata_q;
	logic       [1:0]  resp_q;
	logic       [31:0] rd_word;
	logic              rd_hit;

	// Register state
	logic       [13:0] pol_q;
	logic              ext_sel_q;
	logic       [13:0] thr_q [arp_pkg::THR_NUM];
	logic       [5:0]  side_cfg_q;
	logic       [5:0]  status_q;
	logic       [5:0]  status_d;
	logic       [5:0]  mask_q;
	logic       [5:0]  mask_d;
	logic              irq_q;

	// Extremes tracking
	logic       [13:0] acc_lo_q;
	logic       [13:0] acc_hi_q;
	logic       [13:0] acc_lo_d;
	logic       [13:0] acc_hi_d;
	logic              acc_seen_q;
	logic       [13:0] low_q;
	logic       [13:0] high_q;
	logic              alert_q;

	// Event pulses from the evaluator
	logic              ev_over;
	logic              ev_under;
	logic              ev_comp_over;
	logic              ev_comp_under;
	logic              ev_diag;
	logic       [15:0] aux_word [arp_pkg::AUX_NUM];

	// Threshold slots sit at consecutive indexes above the base
	function automatic logic thr_hit(input logic [7:0] i);
		thr_hit = (i >= arp_pkg::IDX_THR_BASE)
			&& (i < arp_pkg::IDX_THR_BASE + 8'(arp_pkg::THR_NUM));
	endfunction

	wire        [2:0]  thr_slot = 3'(idx - arp_pkg::IDX_THR_BASE);

	// Cell side decode
	wire               cell_ok  = cell_index_i < 4'(arp_pkg::CELL_NUM);
	wire               cell_bip = cell_ok & pol_q[cell_index_i];
	wire               cell_adc = cell_valid_i & cell_ok
		& (scan_kind_i == arp_pkg::SCAN_ADC);
	// Only the class picked by the extremes select feeds the tracker
	wire               feed     = cell_adc
		& (cell_bip == ext_sel_q);

	// Writes land on the edge where waitrequest is seen low
	wire               wr_ok     = (bus_q == arp_pkg::BUS_ACK) & avs_write_i;
	wire               wr_range  = wr_ok & (idx == arp_pkg::IDX_RANGE);
	wire               wr_thr    = wr_ok & thr_hit(idx);
	wire               wr_side   = wr_ok & (idx == arp_pkg::IDX_SIDE_CFG)
		& be[0];
	wire               wr_status = wr_ok & (idx == arp_pkg::IDX_STATUS)
		& be[0];
	wire               wr_mask   = wr_ok & (idx == arp_pkg::IDX_MASK)
		& be[0];
	// Aux result indexes have no write strobe at all
	wire               wr_aux    = 1'h0;

	// Tracker spread; the class decides signed or unsigned
	wire               seen_d = acc_seen_q | feed;
	wire        [14:0] hi_x   = arp_pkg::ext15(acc_hi_d, ext_sel_q);
	wire        [14:0] lo_x   = arp_pkg::ext15(acc_lo_d, ext_sel_q);
	wire        [15:0] spread = {hi_x[14], hi_x} - {lo_x[14], lo_x};
	wire               mism   = spread
		> {2'h0, thr_q[arp_pkg::THR_MISMATCH]};
	wire               close  = scan_end_i & seen_d;

	wire        [5:0]  ev = {ev_diag, close & mism, ev_comp_under,
		ev_comp_over, ev_under, ev_over};

	// A new event beats a clear landing on the same edge
	assign status_d = (status_q & ~(wr_status ? wd[5:0] : 6'h00)) | ev;
	assign mask_d   = wr_mask ? wd[5:0] : mask_q;

	always_comb begin
		bus_d = bus_q;
		unique case (bus_q)
			arp_pkg::BUS_IDLE: begin
				if (rq) begin
					bus_d = arp_pkg::BUS_ACK;
				end
			end
			arp_pkg::BUS_ACK: begin
				bus_d = arp_pkg::BUS_IDLE;
			end
		endcase
	end

	// One wait state: the word is fetched on the edge that sees the
	// request and stands while waitrequest is low on the next edge
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bus_q   <= arp_pkg::BUS_IDLE;
			wait_q  <= 1'h1;
			rdata_q <= 32'h0000_0000;
			resp_q  <= arp_pkg::RESP_OK;
		end else begin
			bus_q  <= bus_d;
			wait_q <= bus_d != arp_pkg::BUS_ACK;
			if (bus_d == arp_pkg::BUS_ACK) begin
				rdata_q <= avs_read_i ? rd_word : 32'h0000_0000;
				resp_q  <= (rd_hit | wr_aux) ? arp_pkg::RESP_OK
					: arp_pkg::RESP_SLVERR;
			end
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'h1;
		if (thr_hit(idx)) begin
			rd_word = {18'h0_0000, thr_q[thr_slot]};
		end else begin
			unique case (idx)
				arp_pkg::IDX_SIDE_RESULT_THREE: begin
					rd_word = {16'h0000, aux_word[0]};
				end
				arp_pkg::IDX_SIDE_RESULT_FOUR: begin
					rd_word = {16'h0000, aux_word[1]};
				end
				arp_pkg::IDX_SIDE_RESULT_FIVE: begin
					rd_word = {16'h0000, aux_word[2]};
				end
				arp_pkg::IDX_RANGE: begin
					rd_word = {16'h0000, ext_sel_q, 1'h0,
						pol_q};
				end
				arp_pkg::IDX_SIDE_CFG: begin
					rd_word = {26'h000_0000, side_cfg_q};
				end
				arp_pkg::IDX_LOWEST: begin
					rd_word = {18'h0_0000, low_q};
				end
				arp_pkg::IDX_HIGHEST: begin
					rd_word = {18'h0_0000, high_q};
				end
				arp_pkg::IDX_STATUS: begin
					rd_word = {26'h000_0000, status_q};
				end
				arp_pkg::IDX_MASK: begin
					rd_word = {26'h000_0000, mask_q};
				end
				default: begin
					rd_hit = 1'h0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pol_q     <= arp_pkg::RST_POL;
			ext_sel_q <= arp_pkg::RST_EXT_SEL;
		end else if (wr_range) begin
			pol_q     <= arp_pkg::merge14(pol_q, wd, be);
			ext_sel_q <= be[1] ? wd[arp_pkg::EXT_SEL_BIT] : ext_sel_q;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int s = 0; s < arp_pkg::THR_NUM; s++) begin
				thr_q[s] <= arp_pkg::RST_THR;
			end
		end else if (wr_thr) begin
			thr_q[thr_slot] <= arp_pkg::merge14(thr_q[thr_slot], wd, be);
		end
	end

	// Interrupt follows the next status and mask, so it moves on the
	// same edge as the write that clears or masks
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			side_cfg_q <= arp_pkg::RST_SIDE_CFG;
			status_q   <= 6'h00;
			mask_q     <= arp_pkg::RST_MASK;
			irq_q      <= 1'h0;
		end else begin
			if (wr_side) begin
				side_cfg_q <= wd[5:0];
			end
			status_q <= status_d;
			mask_q   <= mask_d;
			irq_q    <= |(status_d & ~mask_d);
		end
	end

	always_comb begin
		acc_lo_d = acc_lo_q;
		acc_hi_d = acc_hi_q;
		if (feed) begin
			if (!acc_seen_q || arp_pkg::exceeds(acc_lo_q, cell_value_i,
				ext_sel_q)) begin
				acc_lo_d = cell_value_i;
			end
			if (!acc_seen_q || arp_pkg::exceeds(cell_value_i, acc_hi_q,
				ext_sel_q)) begin
				acc_hi_d = cell_value_i;
			end
		end
	end

	// Changing the extremes select mid-scan mixes classes until the
	// scan ends; software should switch between scans
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			acc_lo_q   <= arp_pkg::RST_RESULT;
			acc_hi_q   <= arp_pkg::RST_RESULT;
			acc_seen_q <= 1'h0;
			low_q      <= arp_pkg::RST_RESULT;
			high_q     <= arp_pkg::RST_RESULT;
			alert_q    <= 1'h0;
		end else if (scan_end_i) begin
			acc_seen_q <= 1'h0;
			if (seen_d) begin
				low_q   <= acc_lo_d;
				high_q  <= acc_hi_d;
				alert_q <= mism;
			end
		end else begin
			acc_lo_q   <= acc_lo_d;
			acc_hi_q   <= acc_hi_d;
			acc_seen_q <= seen_d;
		end
	end

	arp_cell_eval i_arp_cell_eval (
		.ref_clk_i                 (ref_clk_i),
		.rst_b_i                   (rst_b_i),
		.valid_i                   (cell_valid_i & cell_ok),
		.kind_i                    (scan_kind_i),
		.value_i                   (cell_value_i),
		.bipolar_i                 (cell_bip),
		.cell_over_threshold_i     (thr_q[arp_pkg::THR_OVER]),
		.cell_under_threshold_i    (thr_q[arp_pkg::THR_UNDER]),
		.bipolar_over_threshold_i  (thr_q[arp_pkg::THR_BIP_OVER]),
		.bipolar_under_threshold_i (thr_q[arp_pkg::THR_BIP_UNDR]),
		.over_o                    (ev_over),
		.under_o                   (ev_under),
		.comparator_over_alert_o   (ev_comp_over),
		.comparator_under_alert_o  (ev_comp_under),
		.diag_fault_o              (ev_diag)
	);

	wire        [2:0]  side_ana = side_cfg_q[2:0];
	wire        [2:0]  side_en  =
		side_cfg_q[arp_pkg::SIDE_EN_LSB +: arp_pkg::AUX_NUM];

	for (genvar k = 0; k < arp_pkg::AUX_NUM; k++) begin : g_aux
		arp_aux_slot i_arp_aux_slot (
			.ref_clk_i                     (ref_clk_i),
			.rst_b_i                       (rst_b_i),
			.analog_side_input_i           (side_ana[k]),
			.side_channel_measure_enable_i (side_en[k]),
			.load_i                        (aux_valid_i
				& (aux_index_i == 2'(k))),
			.value_i                       (aux_value_i),
			.word_o                        (aux_word[k])
		);
	end

	assign avs_readdata_o        = rdata_q;
	assign avs_waitrequest_o     = wait_q;
	assign avs_response_o        = resp_q;
	assign cell_bipolar_o        = pol_q;
	assign cell_mismatch_alert_o = alert_q;
	assign irq_o                 = irq_q;

endmodule

// ---- test/arp_top_monitor.sv ----
// Purpose: Port assertions for arp_top.
// Assumes: Word index in address bits 9:2.
// Notes:   Bound from the bench top file.
`timescale 1ns/100ps
module arp_top_monitor (
	input wire logic        ref_clk_i,
	input wire logic        rst_b_i,
	input wire logic [9:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0]  avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic [13:0] cell_bipolar_o,
	input wire logic        cell_mismatch_alert_o,
	input wire logic        irq_o
);
	wire        rq  = avs_read_i | avs_write_i;
	wire        ack = rq & ~avs_waitrequest_o;
	wire [7:0]  idx = avs_address_i[9:2];
	wire [13:0] wd  = avs_writedata_i[13:0];
	wire        aux = idx inside {8'h5C, 8'h5D, 8'h5E};
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence range_wr;
		ack && avs_write_i && idx == arp_pkg::IDX_RANGE;
	endsequence
	sequence range_rd;
		ack && avs_read_i && idx == arp_pkg::IDX_RANGE;
	endsequence
	a_wait_bound: assert property (rq |-> ##[0:2] ack)
		else $error("request not answered");
	a_range_take: assert property (
		range_wr ##0 avs_byteenable_i[1:0] == 2'h3
		|=> cell_bipolar_o == $past(wd))
		else $error("range write lost");
	a_range_hold: assert property (
		!$stable(cell_bipolar_o) |-> $past(avs_write_i))
		else $error("range moved alone");
	a_range_rst: assert property (
		$rose(rst_b_i) |-> cell_bipolar_o == 14'h0)
		else $error("range not cleared");
	a_range_read: assert property (
		range_rd |-> avs_readdata_o[14:0] == {1'h0, cell_bipolar_o})
		else $error("range read wrong");
	a_aux_pad: assert property (
		ack && avs_read_i && aux |-> avs_readdata_o[1:0] == 2'h0)
		else $error("aux low bits set");
	a_alert_rst: assert property (
		$rose(rst_b_i) |-> !cell_mismatch_alert_o)
		else $error("alert after reset");
	a_irq_rst: assert property ($rose(rst_b_i) |-> !irq_o)
		else $error("irq after reset");
endmodule

// ---- test/aux_result_and_cell_polarity_tb.sv ----
// Purpose: Self-checking bench for arp_top.
// Assumes: Side config bits 2:0 pick analogue pins, 5:3 enables.
// Notes:   Aux index 1 feeds the channel four result.
`timescale 1ns/100ps
module aux_result_and_cell_polarity_tb;
	logic        ref_clk_i = 1'b0, rst_b_i = 1'b0, avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0, cell_valid_i = 1'b0, aux_valid_i = 1'b0;
	logic        scan_end_i = 1'b0, avs_waitrequest_o, cell_mismatch_alert_o;
	logic        irq_o;
	logic [9:0]  avs_address_i = 10'h000;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rdat;
	logic [3:0]  avs_byteenable_i = 4'hF, cell_index_i = 4'h0;
	logic [1:0]  scan_kind_i = 2'h0, aux_index_i = 2'h0, avs_response_o;
	logic [13:0] cell_value_i = 14'h0, aux_value_i = 14'h0, cell_bipolar_o;
	int          num_errors = 0, comparisons = 0, cyc = 0;
	// Scan kind, cell, value, status; cell 1 is bipolar
	logic [25:0] rows [8] = '{{2'h0, 4'h0, 14'h0200, 6'h01},
		{2'h0, 4'h1, 14'h0200, 6'h00}, {2'h0, 4'h1, 14'h0400, 6'h01},
		{2'h0, 4'h1, 14'h3E00, 6'h02}, {2'h1, 4'h0, 14'h0200, 6'h04},
		{2'h1, 4'h1, 14'h0400, 6'h00}, {2'h2, 4'h1, 14'h3E00, 6'h00},
		{2'h2, 4'h0, 14'h0200, 6'h20}};
	logic [13:0] thr [5] = '{14'h0100, 14'h0000, 14'h0300, 14'h3F00,
		14'h3FFF};
	arp_top i_arp_top (.*);
	always #4 ref_clk_i = ~ref_clk_i;
	task automatic conclude;
		if (num_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] i,
		input logic [31:0] d);
		@(posedge ref_clk_i);
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_address_i <= {i, 2'h0};
		avs_writedata_i <= d;
		do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
		rdat = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	task automatic feed(input logic [19:0] r);
		@(posedge ref_clk_i);
		{scan_kind_i, cell_index_i, cell_value_i} <= r;
		cell_valid_i <= 1'b1;
		@(posedge ref_clk_i);
		cell_valid_i <= 1'b0;
	endtask
	task automatic close_scan;
		@(posedge ref_clk_i);
		scan_end_i <= 1'b1;
		@(posedge ref_clk_i);
		scan_end_i <= 1'b0;
	endtask
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			conclude();
		end
	end
	initial begin
		repeat (4) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		bus(1'b0, arp_pkg::IDX_RANGE, 32'h0);
		chk(rdat, 32'h0);
		bus(1'b1, arp_pkg::IDX_RANGE, 32'hFFFF);
		bus(1'b1, 8'h00, 32'h0);
		bus(1'b0, arp_pkg::IDX_RANGE, 32'h0);
		chk(rdat, 32'hBFFF);
		chk({18'h0, cell_bipolar_o}, 32'h3FFF);
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, arp_pkg::IDX_THR_BASE + i[7:0], {18'h0, thr[i]});
		end
		bus(1'b1, arp_pkg::IDX_RANGE, 32'h2);
		foreach (rows[n]) begin
			feed(rows[n][25:6]);
			repeat (4) @(posedge ref_clk_i);
			bus(1'b0, arp_pkg::IDX_STATUS, 32'h0);
			chk(rdat, {26'h0, rows[n][5:0]});
			chk({31'h0, irq_o}, {31'h0, |rows[n][5:0]});
			bus(1'b1, arp_pkg::IDX_MASK, 32'h3F);
			@(posedge ref_clk_i);
			chk({31'h0, irq_o}, 32'h0);
			bus(1'b1, arp_pkg::IDX_MASK, 32'h0);
			bus(1'b1, arp_pkg::IDX_STATUS, 32'h3F);
		end
		// Unipolar scan: bipolar cell 1 must not widen the spread
		bus(1'b1, arp_pkg::IDX_THR_BASE + 8'h04, 32'h0200);
		feed({2'h0, 4'h2, 14'h0500});
		feed({2'h0, 4'h1, 14'h3000});
		close_scan();
		repeat (2) @(posedge ref_clk_i);
		chk({31'h0, cell_mismatch_alert_o}, 32'h1);
		bus(1'b0, arp_pkg::IDX_HIGHEST, 32'h0);
		chk(rdat, 32'h0500);
		bus(1'b0, arp_pkg::IDX_LOWEST, 32'h0);
		chk(rdat, 32'h0200);
		bus(1'b0, arp_pkg::IDX_STATUS, 32'h0);
		chk(rdat & 32'h10, 32'h10);
		// Bipolar scan: signed order, unipolar cell 0 left out
		bus(1'b1, arp_pkg::IDX_RANGE, 32'h8006);
		feed({2'h0, 4'h1, 14'h3F00});
		feed({2'h0, 4'h2, 14'h0010});
		feed({2'h0, 4'h0, 14'h3000});
		close_scan();
		bus(1'b0, arp_pkg::IDX_HIGHEST, 32'h0);
		chk(rdat, 32'h0010);
		bus(1'b0, arp_pkg::IDX_LOWEST, 32'h0);
		chk(rdat, 32'h3F00);
		chk({31'h0, cell_mismatch_alert_o}, 32'h0);
		bus(1'b1, arp_pkg::IDX_SIDE_CFG, 32'h3F);
		aux_index_i <= 2'h1;
		aux_value_i <= 14'h2ABC;
		aux_valid_i <= 1'b1;
		@(posedge ref_clk_i);
		aux_valid_i <= 1'b0;
		bus(1'b0, arp_pkg::IDX_SIDE_RESULT_FOUR, 32'h0);
		chk(rdat, 32'hAAF0);
		bus(1'b1, arp_pkg::IDX_SIDE_RESULT_FOUR, 32'hFFFF);
		bus(1'b0, arp_pkg::IDX_SIDE_RESULT_FOUR, 32'h0);
		chk(rdat, 32'hAAF0);
		bus(1'b1, arp_pkg::IDX_SIDE_CFG, 32'h5);
		bus(1'b0, arp_pkg::IDX_SIDE_RESULT_FOUR, 32'h0);
		chk(rdat, 32'h0);
		bus(1'b1, arp_pkg::IDX_SIDE_CFG, 32'h7);
		aux_value_i <= 14'h1111;
		aux_valid_i <= 1'b1;
		@(posedge ref_clk_i);
		aux_valid_i <= 1'b0;
		bus(1'b0, arp_pkg::IDX_SIDE_RESULT_FOUR, 32'h0);
		chk(rdat, 32'hAAF0);
		// Reset in mid-run clears range, side config and the alert
		rst_b_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		chk({31'h0, cell_mismatch_alert_o}, 32'h0);
		bus(1'b0, arp_pkg::IDX_RANGE, 32'h0);
		chk(rdat, 32'h0);
		bus(1'b0, arp_pkg::IDX_SIDE_RESULT_FOUR, 32'h0);
		chk(rdat, 32'h0);
		conclude();
	end
endmodule
bind arp_top arp_top_monitor i_arp_top_monitor (.*);
